// file: rtl/byte_reg.v
`timescale 1ns/10ps
// One read/write byte register with hard and soft reset
module byte_reg #(
  parameter [7:0] ADDR = 8'h00,
  parameter [7:0] RESET_VAL = 8'h00
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  input wire soft_rst,
  // Write port
  input wire wr_en,
  input wire [7:0] wr_addr,
  input wire [7:0] wr_data,
  // Stored value
  output reg [7:0] value_q
);

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      value_q <= RESET_VAL;
    end else if (soft_rst) begin
      value_q <= RESET_VAL;
    end else if (wr_en && (wr_addr == ADDR)) begin
      value_q <= wr_data;
    end
  end

endmodule

// file: rtl/demod_regs_defs.vh
`ifndef DEMOD_REGS_DEFS_VH
`define DEMOD_REGS_DEFS_VH

// Register addresses
`define ADDR_PREPROC_SYNC_STATUS 8'h03
`define ADDR_SOFT_RESET 8'h05
`define ADDR_GAIN_TARGET_LO 8'h10
`define ADDR_GAIN_TARGET_HI 8'h11

// Reset values
`define RST_PREPROC_SYNC_STATUS 8'h00
`define RST_GAIN_TARGET 16'h0000

// Status field positions
`define STATE_CODE_MSB 3
`define STATE_CODE_LSB 0
`define GAIN_LOCK_BIT 7

// Synchronisation state codes
`define STATE_COLD_RESET 4'h0
`define STATE_INITIALISE 4'h1
`define STATE_COARSE_TIMING 4'h2
`define STATE_FINE_TIMING_A 4'h3
`define STATE_FINE_TIMING_B 4'h4
`define STATE_TRACKING 4'h5
`define STATE_LOST_LOCK 4'h6

// Soft reset command value and pulse length
`define SOFT_RESET_CMD 8'h01
`define SOFT_RESET_CYCLES 4'h4

`endif

// file: rtl/demod_status_register_bank.v
// Behaviour
// - Each register is chosen by its own byte address in the host transaction.
// - A parameter wider than a byte spans consecutive byte addresses, low byte first.
// - Signed values are two's complement and never-negative values plain unsigned binary.
// - All registers return to their defaults after chip reset and after the soft reset.
// - In each field the most significant bit sits at the highest bit position.
// - Every register is read only, write only or read/write, and is used only that way.
// - Status bits 3 to 0 give the synchronisation state, codes 0 to 6.
// - Status bit 7 is set while the gain loop is locked.
`timescale 1ns/10ps
`include "demod_regs_defs.vh"
module demod_status_register_bank (
  // Clock and reset
  input wire core_clk,
  input wire nrst,
  // Host byte access from serial control bus slave
  input wire host_wr,
  input wire host_rd,
  input wire [7:0] host_addr,
  input wire [7:0] host_wdata,
  output wire [7:0] host_rdata,
  output wire host_rvalid,
  // Pre-processor status
  input wire [3:0] preproc_state_code,
  input wire gain_loop_locked,
  // Control to pre-processor
  output wire [15:0] gain_target,
  output wire soft_reset_active
);

  // Field layout and fixed values
  localparam [15:0] GAIN_TARGET_RST = `RST_GAIN_TARGET;
  localparam [3:0] SRST_IDLE = 4'h0;
  localparam [3:0] SRST_STEP = 4'h1;
  localparam [2:0] RESERVED_ZERO = 3'h0;
  localparam [7:0] UNMAPPED_DATA = 8'h00;

  // Reset synchroniser
  reg rst_s1_q;
  reg rst_s2_q;
  wire rst_n;

  // Address decode
  wire hit_status;
  wire hit_soft_reset;
  wire hit_tgt_lo;
  wire hit_tgt_hi;
  wire can_read;
  wire can_write;

  // Write acceptance
  wire wr_ok;
  wire wr_reg;
  wire srst_cmd;

  // Soft reset sequencing
  reg [3:0] srst_cnt_q;
  reg [3:0] srst_cnt_d;
  reg soft_rst_q;
  reg soft_rst_d;
  wire soft_rst;

  // Gain target bytes
  wire [7:0] tgt_lo;
  wire [7:0] tgt_hi;

  // Status capture
  wire [3:0] state_field;
  wire lock_field;
  reg [7:0] status_d;
  reg [7:0] status_q;

  // Read path
  reg [7:0] rdata_d;
  reg [7:0] rdata_q;
  reg rvalid_q;

  // Reset release synchroniser
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  assign hit_status = (host_addr == `ADDR_PREPROC_SYNC_STATUS);
  assign hit_soft_reset = (host_addr == `ADDR_SOFT_RESET);
  assign hit_tgt_lo = (host_addr == `ADDR_GAIN_TARGET_LO);
  assign hit_tgt_hi = (host_addr == `ADDR_GAIN_TARGET_HI);

  assign can_read = hit_status | hit_tgt_lo | hit_tgt_hi;
  assign can_write = hit_soft_reset | hit_tgt_lo | hit_tgt_hi;

  assign wr_ok = host_wr & ~soft_rst;
  assign wr_reg = wr_ok & can_write;
  assign srst_cmd = wr_reg & hit_soft_reset & (host_wdata == `SOFT_RESET_CMD);

  always @* begin
    srst_cnt_d = srst_cnt_q;
    if (srst_cmd) begin
      srst_cnt_d = `SOFT_RESET_CYCLES;
    end else if (srst_cnt_q != SRST_IDLE) begin
      srst_cnt_d = srst_cnt_q - SRST_STEP;
    end
  end

  always @* begin
    soft_rst_d = (srst_cnt_d != SRST_IDLE);
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      srst_cnt_q <= SRST_IDLE;
    end else begin
      srst_cnt_q <= srst_cnt_d;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= soft_rst_d;
    end
  end
  assign soft_rst = soft_rst_q;
  assign soft_reset_active = soft_rst_q;

  byte_reg #(
    .ADDR(`ADDR_GAIN_TARGET_LO),
    .RESET_VAL(GAIN_TARGET_RST[7:0])
  ) u_tgt_lo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .soft_rst(soft_rst),
    .wr_en(wr_reg),
    .wr_addr(host_addr),
    .wr_data(host_wdata),
    .value_q(tgt_lo)
  );

  byte_reg #(
    .ADDR(`ADDR_GAIN_TARGET_HI),
    .RESET_VAL(GAIN_TARGET_RST[15:8])
  ) u_tgt_hi (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .soft_rst(soft_rst),
    .wr_en(wr_reg),
    .wr_addr(host_addr),
    .wr_data(host_wdata),
    .value_q(tgt_hi)
  );
  assign gain_target = {tgt_hi, tgt_lo};

  assign state_field = preproc_state_code;
  assign lock_field = gain_loop_locked;

  always @* begin
    status_d = `RST_PREPROC_SYNC_STATUS;
    status_d[`STATE_CODE_MSB:`STATE_CODE_LSB] = state_field;
    status_d[`GAIN_LOCK_BIT - 1:`STATE_CODE_MSB + 1] = RESERVED_ZERO;
    status_d[`GAIN_LOCK_BIT] = lock_field;
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= `RST_PREPROC_SYNC_STATUS;
    end else if (soft_rst) begin
      status_q <= `RST_PREPROC_SYNC_STATUS;
    end else begin
      status_q <= status_d;
    end
  end

  always @* begin
    rdata_d = UNMAPPED_DATA;
    if (can_read) begin
      case (host_addr)
        `ADDR_PREPROC_SYNC_STATUS: begin
          rdata_d = status_q;
        end
        `ADDR_GAIN_TARGET_LO: begin
          rdata_d = tgt_lo;
        end
        `ADDR_GAIN_TARGET_HI: begin
          rdata_d = tgt_hi;
        end
        default: begin
          rdata_d = UNMAPPED_DATA;
        end
      endcase
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= host_rd;
    end
  end

  // Read data holds until next read
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= UNMAPPED_DATA;
    end else if (host_rd) begin
      rdata_q <= rdata_d;
    end
  end

  assign host_rdata = rdata_q;
  assign host_rvalid = rvalid_q;

endmodule

// file: tb/demod_status_register_bank_bench.sv
`timescale 1ns/10ps
module demod_status_register_bank_bench;
  reg core_clk = 0, nrst = 0, host_wr = 0, host_rd = 0, step = 0;
  reg [7:0] host_addr = 8'h00, host_wdata = 8'h00;
  wire [7:0] host_rdata;
  wire host_rvalid, soft_reset_active, gain_loop_locked;
  wire [15:0] gain_target;
  wire [3:0] preproc_state_code;
  integer bad_count = 0, compares = 0, i;
  initial forever #2 core_clk = ~core_clk;
  demod_status_register_bank uut(.*);
  preproc_model pm(.*);
  task chk(input [7:0] g, input [7:0] e);
    compares = compares + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("mismatch %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge core_clk);
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge core_clk);
    host_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge core_clk);
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge core_clk);
    host_rd <= 1'b0;
    #1 chk({7'h00, host_rvalid}, 8'h01);
    chk(host_rdata, e);
  endtask
  task t_status;
    for (i = 0; i < 7; i = i + 1) begin
      rd(8'h03, {preproc_state_code == 4'h5, 3'h0, preproc_state_code});
      @(posedge core_clk);
      step <= 1'b1;
      @(posedge core_clk);
      step <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
    $display("status test done");
  endtask
  task t_regs;
    wr(8'h10, 8'ha5);
    wr(8'h11, 8'h3c);
    wr(8'h03, 8'hff);
    rd(8'h03, {preproc_state_code == 4'h5, 3'h0, preproc_state_code});
    rd(8'h10, 8'ha5);
    rd(8'h11, 8'h3c);
    rd(8'h20, 8'h00);
    rd(8'h05, 8'h00);
    $display("register test done");
  endtask
  task t_soft;
    wr(8'h05, 8'h01);
    wr(8'h10, 8'h77);
    repeat (6) @(posedge core_clk);
    rd(8'h10, 8'h00);
    rd(8'h11, 8'h00);
    $display("soft reset test done");
  endtask
  task t_hard;
    wr(8'h10, 8'h5a);
    wr(8'h11, 8'hc3);
    rd(8'h10, 8'h5a);
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(8'h10, 8'h00);
    rd(8'h11, 8'h00);
    rd(8'h03, {preproc_state_code == 4'h5, 3'h0, preproc_state_code});
    $display("hard reset test done");
  endtask
  task wrap_up;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_status;
    t_regs;
    t_soft;
    t_hard;
    wrap_up;
  end
  initial begin
    #20000;
    $display("mismatch %0t watchdog expired", $time);
    bad_count = bad_count + 1;
    wrap_up;
  end
endmodule

// file: tb/demod_status_register_bank_properties.sv
`timescale 1ns/10ps
module demod_bank_checker(
  // Host side
  input wire core_clk, input wire nrst, input wire host_wr, input wire host_rd,
  input wire [7:0] host_addr, input wire [7:0] host_wdata, input wire [7:0] host_rdata,
  input wire host_rvalid,
  // Pre-processor side
  input wire [3:0] preproc_state_code, input wire gain_loop_locked,
  input wire [15:0] gain_target, input wire soft_reset_active);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire st = host_rd && host_addr == 8'h03;
  wire go = host_wr && !soft_reset_active;
  sequence s_soft; soft_reset_active [*4] ##1 !soft_reset_active; endsequence
  a_read_ack: assert property (host_rd |=> host_rvalid) else $error("no ack");
  a_state_code: assert property (st && $stable(preproc_state_code)
    && !$past(soft_reset_active)
    |=> host_rdata[3:0] == $past(preproc_state_code)) else $error("state");
  a_lock_bit: assert property (st && $stable(gain_loop_locked)
    && !$past(soft_reset_active)
    |=> host_rdata[7] == $past(gain_loop_locked)) else $error("lock");
  a_reserved_zero: assert property (st |=> host_rdata[6:4] == 3'h0) else $error("rsvd");
  a_soft_pulse: assert property (go && host_addr == 8'h05 && host_wdata == 8'h01
    |=> s_soft) else $error("soft");
  a_soft_default: assert property ($fell(soft_reset_active)
    |-> gain_target == 16'h0000) else $error("dflt");
  a_low_byte: assert property (go && host_addr == 8'h10
    |=> gain_target[7:0] == $past(host_wdata)) else $error("lo");
  a_high_byte: assert property (go && host_addr == 8'h11
    |=> gain_target[15:8] == $past(host_wdata)) else $error("hi");
  a_unmapped_read: assert property (host_rd && host_addr == 8'h20
    |=> host_rdata == 8'h00) else $error("unmapped");
endmodule
bind demod_status_register_bank demod_bank_checker chk_i(.*);

// file: tb/preproc_model.sv
`timescale 1ns/10ps
module preproc_model(input wire core_clk, input wire step,
  output reg [3:0] preproc_state_code = 4'h0, output wire gain_loop_locked);
  always @(posedge core_clk)
    if (step)
      preproc_state_code <= preproc_state_code == 4'h6 ? 4'h0 : preproc_state_code + 4'h1;
  assign gain_loop_locked = preproc_state_code == 4'h5;
endmodule
